// ==== hdl/sbpc_pkg.sv ====
// constants, types and layout for the shutter bridge power control block
package sbpc_pkg;
	// timing
	localparam int unsigned CLK_KHZ        = 250000;
	localparam int unsigned DEBOUNCE_MS    = 32;
	localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * CLK_KHZ;
	localparam int unsigned DEB_W          = 24;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_STATUS     = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT   = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0c;

	// control register: bit 0 requests power-off, bit 1 forces bridges discharge_state
	localparam int unsigned CTRL_OFF_BIT   = 0;
	localparam int unsigned CTRL_GND_BIT   = 1;
	localparam int unsigned CTRL_W         = 2;

	// interrupt events, same layout in status and mask
	localparam int unsigned EV_ON          = 0;
	localparam int unsigned EV_OFF         = 1;
	localparam int unsigned EV_THERM       = 2;
	localparam int unsigned EV_SLEEP       = 3;
	localparam int unsigned EV_W           = 4;

	localparam logic [1:0] HTRANS_NONSEQ_B = 2'h2;

	typedef enum logic [1:0] {
		SBPC_PWR_OFF = 2'b01,
		SBPC_PWR_ON  = 2'b10
	} sbpc_pwr_e;

	typedef enum logic [3:0] {
		SBPC_BR_OPEN   = 4'b0001,
		SBPC_BR_POS    = 4'b0010,
		SBPC_BR_NEG    = 4'b0100,
		SBPC_BR_GROUND = 4'b1000
	} sbpc_br_e;

	// switch controls of one full bridge
	typedef struct packed {
		logic pos_hi;
		logic pos_lo;
		logic neg_hi;
		logic neg_lo;
	} sbpc_bridge_s;

	// control inputs of one bridge from the core
	typedef struct packed {
		logic ctl_hi;
		logic ctl_lo;
	} sbpc_bridge_ctl_s;

	typedef struct packed {
		sbpc_pwr_e           pwr;
		logic [DEB_W-1:0]    deb_cnt;
		logic                deb_done;
		logic                sleep_prev;
		logic                slider_block;
		sbpc_bridge_s        left;
		sbpc_bridge_s        right;
		logic                boost_en;
		logic [CTRL_W-1:0]   ctrl;
		logic [EV_W-1:0]     irq_stat;
		logic [EV_W-1:0]     irq_mask;
		logic                irq;
		logic                dp_wr;
		logic [7:0]          dp_addr;
		logic [31:0]         rdata;
	} sbpc_state_s;
endpackage

// ==== hdl/sbpc_top.sv ====
// shutter bridge decoder, power sequencer and ahb-lite register slave
`timescale 1ns/1ps
module sbpc_top #(
	parameter int unsigned DEB_CYCLES = sbpc_pkg::DEBOUNCE_CYC
) (
	// clock and reset
	input  wire logic                      ref_clk_i,
	input  wire logic                      reset_i,
	// ahb-lite slave
	input  wire logic                      hsel_i,
	input  wire logic [31:0]               haddr_i,
	input  wire logic [1:0]                htrans_i,
	input  wire logic                      hwrite_i,
	input  wire logic [2:0]                hsize_i,
	input  wire logic [31:0]               hwdata_i,
	input  wire logic                      hready_i,
	output logic      [31:0]               hrdata_o,
	output logic                           hreadyout_o,
	output logic                           hresp_o,
	// core control lines
	input  wire sbpc_pkg::sbpc_bridge_ctl_s left_bridge_ctl_i,
	input  wire sbpc_pkg::sbpc_bridge_ctl_s right_bridge_ctl_i,
	input  wire logic                      boost_on_i,
	input  wire logic                      sleep_req_i,
	// power inputs
	input  wire logic                      thermal_shutdown_i,
	input  wire logic                      power_switch_i,
	input  wire logic                      switch_type_select_i,
	// bridge switches, power outputs, interrupt
	output sbpc_pkg::sbpc_bridge_s         left_bridge_o,
	output sbpc_pkg::sbpc_bridge_s         right_bridge_o,
	output logic                           boost_switch_en_o,
	output logic                           regulator_output_en_o,
	output logic                           irq_o
);
	localparam int unsigned                DEB_LAST_I = DEB_CYCLES - 1;
	localparam logic [sbpc_pkg::DEB_W-1:0] DEB_LAST   = DEB_LAST_I[sbpc_pkg::DEB_W-1:0];
	localparam int unsigned                EV_W_L     = sbpc_pkg::EV_W;

	// power-off request bit is a strobe and never stays set
	localparam int unsigned                 CTRL_OFF_MASK_I = 1 << sbpc_pkg::CTRL_OFF_BIT;
	localparam logic [sbpc_pkg::CTRL_W-1:0] CTRL_OFF_MASK   =
		CTRL_OFF_MASK_I[sbpc_pkg::CTRL_W-1:0];

	sbpc_pkg::sbpc_state_s st;
	sbpc_pkg::sbpc_state_s next_st;

	// one bridge: control pair to switch pattern
	function automatic sbpc_pkg::sbpc_bridge_s bridge_decode(
		input sbpc_pkg::sbpc_bridge_ctl_s ctl,
		input logic                       boost
	);
		sbpc_pkg::sbpc_bridge_s sw;
		sw = '0;
		if (!boost) begin
			sw.pos_lo = 1'b1;
			sw.neg_lo = 1'b1;
		end else begin
			case ({ctl.ctl_hi, ctl.ctl_lo})
				2'b01: begin
					sw.pos_hi = 1'b1;
					sw.neg_lo = 1'b1;
				end
				2'b10: begin
					sw.neg_hi = 1'b1;
					sw.pos_lo = 1'b1;
				end
				2'b11: begin
					sw.pos_lo = 1'b1;
					sw.neg_lo = 1'b1;
				end
				default: sw = '0;
			endcase
		end
		return sw;
	endfunction

	logic        addr_ph;
	logic        pressed;
	logic        sleep_fall;
	logic        therm;
	logic        soft_off;
	logic        want_on;
	logic        want_off;
	logic        boost_ok;
	logic [EV_W_L-1:0] ev;

	assign addr_ph    = hsel_i && htrans_i == sbpc_pkg::HTRANS_NONSEQ_B && hready_i;
	assign pressed    = !power_switch_i;
	assign sleep_fall = st.sleep_prev && !sleep_req_i;
	assign therm      = thermal_shutdown_i;
	assign soft_off   = st.dp_wr && st.dp_addr == sbpc_pkg::ADDR_CTRL
	                    && hwdata_i[sbpc_pkg::CTRL_OFF_BIT];

	always_comb begin
		next_st  = st;
		want_on  = 1'b0;
		want_off = therm || sleep_fall || soft_off;

		if (switch_type_select_i) begin
			// push-button: one counter serves on and off alike
			next_st.slider_block = 1'b0;
			if (!pressed) begin
				next_st.deb_cnt  = '0;
				next_st.deb_done = 1'b0;
			end else if (!st.deb_done) begin
				if (st.deb_cnt == DEB_LAST) begin
					next_st.deb_done = 1'b1;
					if (st.pwr == sbpc_pkg::SBPC_PWR_OFF)
						want_on = 1'b1;
					else
						want_off = 1'b1;
				end else begin
					next_st.deb_cnt = st.deb_cnt + 1'b1;
				end
			end
		end else begin
			// slider: a forced off holds until the slider is moved to off
			next_st.deb_cnt  = '0;
			next_st.deb_done = 1'b0;
			if (want_off)
				next_st.slider_block = 1'b1;
			else if (!pressed)
				next_st.slider_block = 1'b0;
			if (pressed && !st.slider_block)
				want_on = 1'b1;
			else if (!pressed)
				want_off = 1'b1;
		end

		case (st.pwr)
			sbpc_pkg::SBPC_PWR_OFF: begin
				if (want_on && !want_off)
					next_st.pwr = sbpc_pkg::SBPC_PWR_ON;
			end
			sbpc_pkg::SBPC_PWR_ON: begin
				if (want_off)
					next_st.pwr = sbpc_pkg::SBPC_PWR_OFF;
			end
			default: next_st.pwr = sbpc_pkg::SBPC_PWR_OFF;
		endcase

		next_st.sleep_prev = sleep_req_i;

		// boost runs only while powered and cool
		boost_ok = boost_on_i && next_st.pwr == sbpc_pkg::SBPC_PWR_ON && !therm;
		next_st.boost_en = boost_ok;
		next_st.left  = bridge_decode(left_bridge_ctl_i,
			boost_ok && !st.ctrl[sbpc_pkg::CTRL_GND_BIT]);
		next_st.right = bridge_decode(right_bridge_ctl_i,
			boost_ok && !st.ctrl[sbpc_pkg::CTRL_GND_BIT]);

		// sticky events; a new event wins over a write-one clear
		ev = '0;
		ev[sbpc_pkg::EV_ON]    = st.pwr == sbpc_pkg::SBPC_PWR_OFF
		                         && next_st.pwr == sbpc_pkg::SBPC_PWR_ON;
		ev[sbpc_pkg::EV_OFF]   = st.pwr == sbpc_pkg::SBPC_PWR_ON
		                         && next_st.pwr == sbpc_pkg::SBPC_PWR_OFF;
		ev[sbpc_pkg::EV_THERM] = therm;
		ev[sbpc_pkg::EV_SLEEP] = sleep_fall;

		// data phase of a write
		if (st.dp_wr) begin
			if (st.dp_addr == sbpc_pkg::ADDR_CTRL)
				next_st.ctrl = hwdata_i[sbpc_pkg::CTRL_W-1:0] & ~CTRL_OFF_MASK;
			else if (st.dp_addr == sbpc_pkg::ADDR_IRQ_STAT)
				next_st.irq_stat = st.irq_stat & ~hwdata_i[EV_W_L-1:0];
			else if (st.dp_addr == sbpc_pkg::ADDR_IRQ_MASK)
				next_st.irq_mask = hwdata_i[EV_W_L-1:0];
		end
		next_st.irq_stat = next_st.irq_stat | ev;
		next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);

		// address phase: latch writes, fetch read data for the data phase
		next_st.dp_wr   = addr_ph && hwrite_i;
		next_st.dp_addr = haddr_i[7:0];
		next_st.rdata   = '0;
		if (addr_ph && !hwrite_i) begin
			if (haddr_i[31:8] != '0)
				next_st.rdata = '0;
			else if (haddr_i[7:0] == sbpc_pkg::ADDR_CTRL)
				next_st.rdata = 32'(next_st.ctrl);
			else if (haddr_i[7:0] == sbpc_pkg::ADDR_STATUS)
				next_st.rdata = 32'({switch_type_select_i, st.boost_en,
					st.pwr == sbpc_pkg::SBPC_PWR_ON});
			else if (haddr_i[7:0] == sbpc_pkg::ADDR_IRQ_STAT)
				next_st.rdata = 32'(st.irq_stat);
			else if (haddr_i[7:0] == sbpc_pkg::ADDR_IRQ_MASK)
				next_st.rdata = 32'(st.irq_mask);
		end
		if (haddr_i[31:8] != '0)
			next_st.dp_wr = 1'b0;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			st            <= '0;
			st.pwr        <= sbpc_pkg::SBPC_PWR_OFF;
			st.left       <= '{pos_hi: 1'b0, pos_lo: 1'b1, neg_hi: 1'b0, neg_lo: 1'b1};
			st.right      <= '{pos_hi: 1'b0, pos_lo: 1'b1, neg_hi: 1'b0, neg_lo: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign hrdata_o              = st.rdata;
	assign hreadyout_o           = 1'b1;
	assign hresp_o               = 1'b0;
	assign left_bridge_o         = st.left;
	assign right_bridge_o        = st.right;
	assign boost_switch_en_o     = st.boost_en;
	assign regulator_output_en_o = st.pwr == sbpc_pkg::SBPC_PWR_ON;
	assign irq_o                 = st.irq;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	a_ground_when_off: assert property (
		!boost_ok |=> left_bridge_o.pos_lo && left_bridge_o.neg_lo
			&& !left_bridge_o.pos_hi && !left_bridge_o.neg_hi
			&& right_bridge_o.pos_lo && right_bridge_o.neg_lo)
		else $error("bridges not discharge_state without boost");
	a_bridge_pos: assert property (
		boost_ok && !st.ctrl[sbpc_pkg::CTRL_GND_BIT] && left_bridge_ctl_i == 2'b01
		|=> left_bridge_o == 4'b1001)
		else $error("positive drive pattern wrong");
	a_bridge_neg: assert property (
		boost_ok && !st.ctrl[sbpc_pkg::CTRL_GND_BIT] && right_bridge_ctl_i == 2'b10
		|=> right_bridge_o == 4'b0110)
		else $error("negative drive pattern wrong");
	a_no_shoot: assert property (
		!(left_bridge_o.pos_hi && left_bridge_o.pos_lo)
		&& !(right_bridge_o.neg_hi && right_bridge_o.neg_lo))
		else $error("bridge leg shorted");
	a_thermal_off: assert property (
		thermal_shutdown_i |=> !boost_switch_en_o && !regulator_output_en_o)
		else $error("thermal shutdown ignored");
	a_sleep_edge: assert property (
		$fell(sleep_req_i) |=> !regulator_output_en_o)
		else $error("sleep edge did not power off");
	a_slider_off: assert property (
		!switch_type_select_i && power_switch_i |=> !regulator_output_en_o)
		else $error("slider off ignored");
	a_boost_drop: assert property (
		!regulator_output_en_o |-> !boost_switch_en_o)
		else $error("boost on while powered off");
	a_short_press: assert property (
		switch_type_select_i && $rose(power_switch_i) |=> st.deb_cnt == '0)
		else $error("debounce not restarted");
	a_press_toggle: assert property (
		switch_type_select_i && pressed && !st.deb_done && st.deb_cnt == DEB_LAST
		&& !want_off && !regulator_output_en_o |=> regulator_output_en_o)
		else $error("accepted press did not power on");

	c_push_on: cover property (switch_type_select_i && $rose(regulator_output_en_o));
	c_slider_on: cover property (!switch_type_select_i && $rose(regulator_output_en_o));
	c_reverse: cover property (left_bridge_o == 4'b1001 ##[1:20] left_bridge_o == 4'b0110);
	c_irq: cover property ($rose(irq_o));
endmodule

// ==== bench/sbpc_core_model.sv ====
// behavioural model of the controller core driving the bridge and power lines
`timescale 1ns/1ps
module sbpc_core_model (
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       reset_i,
	// commands from the bench
	input  wire sbpc_pkg::sbpc_bridge_ctl_s left_cmd_i,
	input  wire sbpc_pkg::sbpc_bridge_ctl_s right_cmd_i,
	input  wire logic                       boost_cmd_i,
	input  wire logic                       sleep_cmd_i,
	// lines into the block
	output sbpc_pkg::sbpc_bridge_ctl_s      left_bridge_ctl_o,
	output sbpc_pkg::sbpc_bridge_ctl_s      right_bridge_ctl_o,
	output logic                            boost_on_o,
	output logic                            sleep_req_o
);
	// pins change only just after an edge, like a port register
	always @(posedge clk_i) begin
		if (reset_i) begin
			left_bridge_ctl_o <= '0;
			right_bridge_ctl_o <= '0;
			boost_on_o <= 1'b0;
			sleep_req_o <= 1'b1;
		end else begin
			left_bridge_ctl_o <= left_cmd_i;
			right_bridge_ctl_o <= right_cmd_i;
			boost_on_o <= boost_cmd_i;
			sleep_req_o <= sleep_cmd_i;
		end
	end
endmodule

// ==== bench/sbpc_tb_top.sv ====
// randomised self-checking bench for the shutter bridge power control block
`timescale 1ns/1ps
module sbpc_tb_top;
	localparam int DEB = 16;
	logic                       clk = 1'b0;
	logic                       rst = 1'b1;
	logic                       hsel = 1'b0;
	logic [31:0]                haddr = 32'h0;
	logic [1:0]                 htrans = 2'h0;
	logic                       hwrite = 1'b0;
	logic [31:0]                hwdata = 32'h0;
	logic [31:0]                hrdata;
	logic                       hready;
	logic                       hresp;
	sbpc_pkg::sbpc_bridge_ctl_s lcmd = '0;
	sbpc_pkg::sbpc_bridge_ctl_s rcmd = '0;
	sbpc_pkg::sbpc_bridge_ctl_s lctl;
	sbpc_pkg::sbpc_bridge_ctl_s rctl;
	logic                       boost_cmd = 1'b1;
	logic                       sleep_cmd = 1'b1;
	logic                       boost_on;
	logic                       sleep_req;
	logic                       therm = 1'b0;
	logic                       sw = 1'b1;
	logic                       sel = 1'b1;
	sbpc_pkg::sbpc_bridge_s     lbr;
	sbpc_pkg::sbpc_bridge_s     rbr;
	logic                       bsw;
	logic                       reg_en;
	logic                       irq;
	logic [31:0]                rd;
	int                         bad_count = 0;
	int                         check_count = 0;
	int                         cycles = 0;
	int                         seed = 16;

	always #2 clk = ~clk;

	sbpc_core_model core (.clk_i(clk), .reset_i(rst), .left_cmd_i(lcmd), .right_cmd_i(rcmd),
		.boost_cmd_i(boost_cmd), .sleep_cmd_i(sleep_cmd), .left_bridge_ctl_o(lctl),
		.right_bridge_ctl_o(rctl), .boost_on_o(boost_on), .sleep_req_o(sleep_req));

	sbpc_top #(.DEB_CYCLES(DEB)) dut (.ref_clk_i(clk), .reset_i(rst), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(hresp), .left_bridge_ctl_i(lctl), .right_bridge_ctl_i(rctl),
		.boost_on_i(boost_on), .sleep_req_i(sleep_req), .thermal_shutdown_i(therm),
		.power_switch_i(sw), .switch_type_select_i(sel), .left_bridge_o(lbr),
		.right_bridge_o(rbr), .boost_switch_en_o(bsw), .regulator_output_en_o(reg_en),
		.irq_o(irq));

	// expected switch pattern of one bridge
	function automatic sbpc_pkg::sbpc_bridge_s dec(sbpc_pkg::sbpc_bridge_ctl_s c, logic gnd);
		if (gnd || (c.ctl_hi && c.ctl_lo))
			return 4'b0101;
		if (c.ctl_hi)
			return 4'b0110;
		if (c.ctl_lo)
			return 4'b1001;
		return 4'b0000;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// single word transfer; read data taken at the data phase edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= sbpc_pkg::HTRANS_NONSEQ_B;
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask

	task automatic wait_reg(input logic v, input int lim);
		int n;
		n = 0;
		while (reg_en !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, reg_en}, {31'h0, v}, "power state");
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			end_of_test();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		cyc(2);
		chk({21'h0, lbr, rbr, bsw, reg_en, irq}, 32'h2a8, "off after reset");
		// early release must restart the press count
		sw <= 1'b0;
		cyc(DEB - 4);
		sw <= 1'b1;
		cyc(2);
		sw <= 1'b0;
		cyc(DEB - 4);
		chk({31'h0, reg_en}, 32'h0, "early press");
		wait_reg(1'b1, 10);
		cyc(3 * DEB);
		chk({31'h0, reg_en}, 32'h1, "long press");
		sw <= 1'b1;
		for (int i = 0; i < 48; i++) begin
			lcmd <= (i < 4) ? 2'(i) : 2'($random(seed));
			rcmd <= 2'($random(seed));
			boost_cmd <= (i < 4) ? 1'b1 : 1'($random(seed));
			cyc(4);
			chk({24'h0, lbr, rbr}, {24'h0, dec(lcmd, !boost_cmd), dec(rcmd, !boost_cmd)},
				"bridges");
			chk({31'h0, bsw}, {31'h0, boost_cmd}, "boost switch");
		end
		// force-ground control bit, then soft power-off strobe
		boost_cmd <= 1'b1;
		lcmd <= 2'b01;
		ahb(1'b1, sbpc_pkg::ADDR_CTRL, 32'h2);
		cyc(4);
		chk({28'h0, lbr}, 32'h5, "forced ground");
		ahb(1'b1, sbpc_pkg::ADDR_CTRL, 32'h0);
		cyc(4);
		chk({28'h0, lbr}, 32'h9, "ground released");
		ahb(1'b1, sbpc_pkg::ADDR_CTRL, 32'h1);
		cyc(2);
		chk({30'h0, reg_en, bsw}, 32'h0, "soft off");
		sw <= 1'b0;
		wait_reg(1'b1, DEB + 8);
		sw <= 1'b1;
		ahb(1'b1, sbpc_pkg::ADDR_IRQ_MASK, 32'h8);
		ahb(1'b0, sbpc_pkg::ADDR_IRQ_MASK, 32'h0);
		chk(rd, 32'h8, "mask");
		sleep_cmd <= 1'b0;
		cyc(4);
		chk({29'h0, reg_en, irq, bsw}, 32'h2, "sleep edge");
		chk({24'h0, lbr, rbr}, 32'h55, "ground after off");
		ahb(1'b0, sbpc_pkg::ADDR_IRQ_STAT, 32'h0);
		chk(rd & 32'h8, 32'h8, "sleep event");
		ahb(1'b1, sbpc_pkg::ADDR_IRQ_STAT, 32'h8);
		cyc(2);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		ahb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		chk({31'h0, hresp}, 32'h0, "okay response");
		sleep_cmd <= 1'b1;
		sw <= 1'b0;
		wait_reg(1'b1, DEB + 8);
		sw <= 1'b1;
		therm <= 1'b1;
		cyc(3);
		chk({22'h0, reg_en, bsw, lbr, rbr}, 32'h55, "thermal off");
		therm <= 1'b0;
		sw <= 1'b0;
		wait_reg(1'b1, DEB + 8);
		sw <= 1'b1;
		cyc(2);
		sw <= 1'b0;
		cyc(DEB - 4);
		chk({31'h0, reg_en}, 32'h1, "off press early");
		wait_reg(1'b0, 10);
		sw <= 1'b1;
		sel <= 1'b0;
		cyc(3);
		chk({31'h0, reg_en}, 32'h0, "slider high");
		sw <= 1'b0;
		cyc(2);
		chk({31'h0, reg_en}, 32'h1, "slider low");
		cyc(2 * DEB);
		chk({31'h0, reg_en}, 32'h1, "slider held");
		sw <= 1'b1;
		cyc(2);
		chk({31'h0, reg_en}, 32'h0, "slider off");
		end_of_test();
	end
endmodule
